// ---- inc/spm_consts.vh ----
// constants for the shared pin function multiplexer
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// ----------------------------------------------------------------------
// structure
// ----------------------------------------------------------------------
`define SPM_NUM_PORTS       5
`define SPM_PORT_W          8
`define SPM_PIN_W           40
`define SPM_ADDR_W          8

// ----------------------------------------------------------------------
// register map, byte addresses, one word each
// port p register k sits at p * 16 + k * 4
// ----------------------------------------------------------------------
`define SPM_KIND_DATA       2'h0
`define SPM_KIND_DIR        2'h1
`define SPM_KIND_PULL       2'h2
`define SPM_KIND_NONE       2'h3
`define SPM_SYSTEM_OPTIONS_REGISTER_ADDR       8'h50

// ----------------------------------------------------------------------
// system options fields and reset values
// ----------------------------------------------------------------------
`define SPM_SYSTEM_OPTIONS_REGISTER_RSTEN_BIT  0
`define SPM_SYSTEM_OPTIONS_REGISTER_DBGEN_BIT  1
`define SPM_SYSTEM_OPTIONS_REGISTER_RESET      2'h3
`define SPM_PORT_RESET      8'h00
`define SPM_PINS_RESET      40'h00_0000_0000
`define SPM_OE_N_RESET      8'hff

// ----------------------------------------------------------------------
// pin positions in the flat 40 bit vectors
// ----------------------------------------------------------------------
`define SPM_PIN_DEBUG       24
`define SPM_PIN_RESET       25
`define SPM_PIN_IRQ         26
`define SPM_KBD_HI_LSB      4

`endif

// ---- verilog/spm_port.v ----
// one eight-pin port: input synchroniser, output selection and pull control
`include "spm_consts.vh"
`default_nettype none

module spm_port (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire [7:0] pad_in,
    input  wire [7:0] port_data,
    input  wire [7:0] port_dir,
    input  wire [7:0] pull_en,
    input  wire [7:0] own_en,
    input  wire [7:0] own_out,
    input  wire [7:0] own_oe,
    input  wire [7:0] out_only,
    input  wire [7:0] pull_force,
    input  wire [7:0] pd_swap,
    output reg  [7:0] pad_out,
    output reg  [7:0] pad_oe_n,
    output reg  [7:0] pull_up,
    output reg  [7:0] pull_down,
    output wire [7:0] read_val,
    output wire [7:0] pin_sync
);

    reg  [7:0] sync_a;
    reg  [7:0] sync_b;
    reg  [7:0] next_drive;
    reg  [7:0] next_value;
    reg  [7:0] next_pull;

    // ------------------------------------------------------------------
    // pad input synchroniser
    // ------------------------------------------------------------------
    // two flops; only the second one is read anywhere
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= pad_in;
            sync_b <= sync_a;
        end
    end

    assign pin_sync = sync_b;

    // direction selects readback
    // output-only pins have no input path, so they read back the latch
    assign read_val = ((port_dir | out_only) & port_data) | (~(port_dir | out_only) & sync_b);

    // ------------------------------------------------------------------
    // output and pull selection
    // ------------------------------------------------------------------
    always @* begin
        next_drive = (own_en & own_oe) | (~own_en & (port_dir | out_only));
        next_value = (own_en & own_out) | (~own_en & port_data);
        next_pull  = (pull_en & ~next_drive) | pull_force;
    end

    // registered pad controls so every pad output has a reset value
    always @(posedge core_clk) begin
        if (sys_rst) begin
            pad_out   <= 8'h00;
            pad_oe_n  <= `SPM_OE_N_RESET;
            pull_up   <= 8'h00;
            pull_down <= 8'h00;
        end else begin
            pad_out   <= next_value;
            pad_oe_n  <= ~next_drive;
            pull_up   <= next_pull & ~pd_swap;
            pull_down <= next_pull & pd_swap;
        end
    end

endmodule // spm_port

`default_nettype wire

// ---- verilog/spm_pin_mux.v ----
// shared pin function multiplexer with its register slave
`include "spm_consts.vh"
`default_nettype none

// Summary of operation
// - after reset all shared pins are undriven inputs with pulls off, except the pullups on the debug and reset pins
// - each pin goes to its port function or its one fixed peripheral
// - peripheral controls the output enable; direction bit still picks the readback
// - pull-enable bit turns the pull on whenever the pin acts as input
// - keyboard pins 7..4 with rising sensitivity use pulldown instead of pullup
// - interrupt request pin with rising edge uses pulldown instead of pullup
// - debug pin as port bit is output-only with pullup shown enabled
// - reset pin as port bit is output-only with no input path
// - reset-pin enable is set by every reset; cleared by software
// - debug pin keeps debug function until debug-pin enable is cleared
module spm_pin_mux (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [39:0] pin_in,
    output wire [39:0] pin_out,
    output wire [39:0] pin_oe_n,
    output wire [39:0] pin_pullup,
    output wire [39:0] pin_pulldown,
    input  wire [39:0] periph_en,
    input  wire [39:0] periph_out,
    input  wire [39:0] periph_oe,
    output wire [39:0] pin_sync,
    input  wire [3:0]  kbd_rising,
    input  wire        irq_rising,
    input  wire        debug_out,
    input  wire        debug_oe,
    output wire        debug_in,
    output wire        reset_pin_low
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg  [39:0] port_data;
    reg  [39:0] port_dir;
    reg  [39:0] port_pull;
    reg         reset_pin_enable;
    reg         debug_pin_enable;
    reg         bus_ack;
    reg  [39:0] own_en;
    reg  [39:0] own_out;
    reg  [39:0] own_oe;
    reg  [39:0] out_only;
    reg  [39:0] pull_force;
    reg  [39:0] pd_swap;
    reg  [7:0]  next_rdata;
    wire [39:0] read_val;
    // options reset word held at its own width so single bits can be picked
    localparam [1:0] system_options_register_reset_val = `SPM_SYSTEM_OPTIONS_REGISTER_RESET;
    wire [5:0]  rd_dec;
    wire [5:0]  wr_dec;
    wire        bus_req;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // result is {valid, port index, register kind}; valid is clear for
    // unmapped or misaligned addresses and for the options register
    function [5:0] spm_decode;
        input [7:0] addr;
        reg   [2:0] port;
        reg   [1:0] kind;
        begin
            port = addr[6:4];
            kind = addr[3:2];
            spm_decode = {1'b0, port, kind};
            if (addr[1:0] == 2'h0 && addr[7] == 1'b0 && port < 3'h5 &&
                kind != `SPM_KIND_NONE) begin
                spm_decode = {1'b1, port, kind};
            end
        end
    endfunction

    assign rd_dec  = spm_decode(avs_address);
    assign wr_dec  = rd_dec;
    assign bus_req = avs_read | avs_write;

    // ------------------------------------------------------------------
    // avalon handshake
    // ------------------------------------------------------------------
    // fixed one wait state: the first cycle of a request loads read data,
    // the second releases waitrequest; writes land on that second edge
    assign avs_waitrequest = bus_req & ~bus_ack;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (avs_address == `SPM_SYSTEM_OPTIONS_REGISTER_ADDR) begin
            next_rdata = {6'h00, debug_pin_enable, reset_pin_enable};
        end else if (rd_dec[5]) begin
            case (rd_dec[1:0])
                `SPM_KIND_DATA: next_rdata = read_val[{rd_dec[4:2], 3'h0} +: 8];
                `SPM_KIND_DIR:  next_rdata = port_dir[{rd_dec[4:2], 3'h0} +: 8];
                `SPM_KIND_PULL: next_rdata = port_pull[{rd_dec[4:2], 3'h0} +: 8];
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    // unmapped reads return zero; data holds until the next read
    always @(posedge core_clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_ack) begin
            avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (sys_rst) begin
            port_data        <= `SPM_PINS_RESET;
            port_dir         <= `SPM_PINS_RESET;
            port_pull        <= `SPM_PINS_RESET;
            reset_pin_enable <= system_options_register_reset_val[`SPM_SYSTEM_OPTIONS_REGISTER_RSTEN_BIT];
            debug_pin_enable <= system_options_register_reset_val[`SPM_SYSTEM_OPTIONS_REGISTER_DBGEN_BIT];
        end else if (avs_write && bus_ack) begin
            if (avs_address == `SPM_SYSTEM_OPTIONS_REGISTER_ADDR) begin
                reset_pin_enable <= avs_writedata[`SPM_SYSTEM_OPTIONS_REGISTER_RSTEN_BIT];
                debug_pin_enable <= avs_writedata[`SPM_SYSTEM_OPTIONS_REGISTER_DBGEN_BIT];
            end else if (wr_dec[5]) begin
                case (wr_dec[1:0])
                    `SPM_KIND_DATA: port_data[{wr_dec[4:2], 3'h0} +: 8] <= avs_writedata[7:0];
                    `SPM_KIND_DIR:  port_dir[{wr_dec[4:2], 3'h0} +: 8]  <= avs_writedata[7:0];
                    `SPM_KIND_PULL: port_pull[{wr_dec[4:2], 3'h0} +: 8] <= avs_writedata[7:0];
                    default:        port_data <= port_data;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // pin ownership
    // ------------------------------------------------------------------
    // debug and reset pins ignore the generic peripheral request lines:
    // their owner is fixed by the system options bits alone
    always @* begin
        own_en     = periph_en;
        own_out    = periph_out;
        own_oe     = periph_oe;
        out_only   = `SPM_PINS_RESET;
        pull_force = `SPM_PINS_RESET;
        pd_swap    = `SPM_PINS_RESET;

        pd_swap[`SPM_KBD_HI_LSB +: 4] = periph_en[`SPM_KBD_HI_LSB +: 4] & kbd_rising;
        pd_swap[`SPM_PIN_IRQ] = periph_en[`SPM_PIN_IRQ] & irq_rising;

        own_en[`SPM_PIN_DEBUG]     = debug_pin_enable;
        own_out[`SPM_PIN_DEBUG]    = debug_out;
        own_oe[`SPM_PIN_DEBUG]     = debug_oe;
        out_only[`SPM_PIN_DEBUG]   = ~debug_pin_enable;
        pull_force[`SPM_PIN_DEBUG] = 1'b1;

        // reset function only listens; the pin is driven only as a port bit, while reset-pin enable is clear
        own_en[`SPM_PIN_RESET]     = reset_pin_enable;
        own_out[`SPM_PIN_RESET]    = 1'b0;
        own_oe[`SPM_PIN_RESET]     = 1'b0;
        out_only[`SPM_PIN_RESET]   = ~reset_pin_enable;
        pull_force[`SPM_PIN_RESET] = reset_pin_enable;
    end

    // ------------------------------------------------------------------
    // per-port pad logic
    // ------------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < `SPM_NUM_PORTS; gp = gp + 1) begin : g_port
            spm_port u_port (
                .core_clk   (core_clk),
                .sys_rst    (sys_rst),
                .pad_in     (pin_in[gp*8 +: 8]),
                .port_data  (port_data[gp*8 +: 8]),
                .port_dir   (port_dir[gp*8 +: 8]),
                .pull_en    (port_pull[gp*8 +: 8]),
                .own_en     (own_en[gp*8 +: 8]),
                .own_out    (own_out[gp*8 +: 8]),
                .own_oe     (own_oe[gp*8 +: 8]),
                .out_only   (out_only[gp*8 +: 8]),
                .pull_force (pull_force[gp*8 +: 8]),
                .pd_swap    (pd_swap[gp*8 +: 8]),
                .pad_out    (pin_out[gp*8 +: 8]),
                .pad_oe_n   (pin_oe_n[gp*8 +: 8]),
                .pull_up    (pin_pullup[gp*8 +: 8]),
                .pull_down  (pin_pulldown[gp*8 +: 8]),
                .read_val   (read_val[gp*8 +: 8]),
                .pin_sync   (pin_sync[gp*8 +: 8])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // system pin inputs
    // ------------------------------------------------------------------
    // no input path once output-only
    assign reset_pin_low = reset_pin_enable & ~pin_sync[`SPM_PIN_RESET];
    assign debug_in      = debug_pin_enable & pin_sync[`SPM_PIN_DEBUG];

endmodule // spm_pin_mux

`default_nettype wire

// ---- dv/spm_pad_model.sv ----
// pad model standing at the far side of the shared pins
`default_nettype none
module spm_pad_model (
    input  wire logic [39:0] pin_out,
    input  wire logic [39:0] pin_oe_n,
    input  wire logic [39:0] pin_pullup,
    input  wire logic [39:0] pin_pulldown,
    input  wire logic [39:0] ext_level,
    output logic      [39:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // buffer then pulls
    // a driven pad wins, else a pull, else whatever the board puts there
    assign pin_in = (~pin_oe_n & pin_out)
                  | (pin_oe_n & (pin_pullup | (~pin_pulldown & ext_level)));
endmodule // spm_pad_model
`default_nettype wire

// ---- dv/spm_pin_mux_sva.sv ----
// concurrent checks on the shared pin multiplexer ports
`default_nettype none
module spm_pin_mux_sva (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe_n,
    input wire logic [39:0] pin_pullup,
    input wire logic [39:0] pin_pulldown,
    input wire logic [39:0] periph_en,
    input wire logic [39:0] periph_out,
    input wire logic [39:0] periph_oe,
    input wire logic [3:0]  kbd_rising,
    input wire logic        irq_rising,
    input wire logic        reset_pin_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // pin relations
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_idle;
        $fell(sys_rst) |-> (&pin_oe_n) && pin_pullup == 40'h0 && pin_pulldown == 40'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("pins not idle at reset");
    property p_own;
        periph_en[15] && periph_oe[15] |=> !pin_oe_n[15] && pin_out[15] == $past(periph_out[15]);
    endproperty
    a_own: assert property (p_own) else $error("peripheral drive lost");
    property p_float;
        periph_en[15] && !periph_oe[15] |=> pin_oe_n[15];
    endproperty
    a_float: assert property (p_float) else $error("peripheral enable ignored");
    property p_pull;
        ((pin_pullup | pin_pulldown) & ~pin_oe_n & 40'hff_fcff_ffff) == 40'h0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull on a driven pin");
    property p_kbd;
        periph_en[7] && kbd_rising[3] |=> !pin_pullup[7];
    endproperty
    a_kbd: assert property (p_kbd) else $error("keyboard pin kept pullup");
    property p_irq;
        periph_en[26] && irq_rising |=> !pin_pullup[26];
    endproperty
    a_irq: assert property (p_irq) else $error("request pin kept pullup");
    property p_dbg;
        !$past(sys_rst) |-> pin_pullup[24];
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug pin pullup off");
    property p_rstpin;
        reset_pin_low |-> pin_oe_n[25];
    endproperty
    a_rstpin: assert property (p_rstpin) else $error("reset pin driven");
endmodule // spm_pin_mux_sva
bind spm_pin_mux spm_pin_mux_sva spm_pin_mux_sva_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .pin_pulldown(pin_pulldown), .periph_en(periph_en), .periph_out(periph_out),
    .periph_oe(periph_oe), .kbd_rising(kbd_rising), .irq_rising(irq_rising),
    .reset_pin_low(reset_pin_low));
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the shared pin multiplexer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [39:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_pulldown, pin_sync;
    logic [39:0] periph_en = 40'h00_0000_0000;
    logic [39:0] periph_out = 40'h00_0000_0000;
    logic [39:0] periph_oe = 40'h00_0000_0000;
    logic [39:0] ext_level = 40'h00_0000_3000;
    logic [3:0]  kbd_rising = 4'h0;
    logic        irq_rising = 1'b0;
    logic        debug_out = 1'b0;
    logic        debug_oe = 1'b0;
    logic        debug_in, reset_pin_low;
    int          error_cnt = 0;
    int          n_tests = 0;
    spm_pin_mux spm_pin_mux_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown),
        .periph_en(periph_en), .periph_out(periph_out), .periph_oe(periph_oe),
        .pin_sync(pin_sync), .kbd_rising(kbd_rising), .irq_rising(irq_rising),
        .debug_out(debug_out), .debug_oe(debug_oe), .debug_in(debug_in),
        .reset_pin_low(reset_pin_low));
    spm_pad_model spm_pad_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .ext_level(ext_level),
        .pin_in(pin_in));
    // ------------------------------------------------------------
    // clock, verdict and bus tasks
    // ------------------------------------------------------------
    // 50 ns period
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic print_verdict;
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // hold the request until waitrequest is sampled low, then idle a cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk("bus answer", 40'h1, 40'h0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk("read data", q, exp);
    endtask
    // cut a hang short
    initial begin
        step(5000);
        error_cnt++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        step(4);
        chk("oe_n reset", pin_oe_n, 40'hff_ffff_ffff);
        chk("pulls reset", pin_pullup | pin_pulldown, 40'h0);
        chk("out reset", pin_out, 40'h0);
        sys_rst <= 1'b0;
        step(2);
        chk("pullups on", pin_pullup, 40'h00_0300_0000);
        rd(8'h50, 32'h3);
        chk("reset pin low", reset_pin_low, 40'h0);
        debug_oe <= 1'b1;
        debug_out <= 1'b1;
        step(2);
        chk("debug drive", {pin_oe_n[24], pin_out[24]}, 40'h1);
        debug_oe <= 1'b0;
        step(3);
        chk("debug in", debug_in, 40'h1);
        wr(8'h50, 8'h00);
        rd(8'h50, 32'h0);
        chk("debug in off", debug_in, 40'h0);
        wr(8'h30, 8'h02);
        chk("d1 d0 drive", {pin_oe_n[25:24], pin_out[25:24]}, 40'h2);
        chk("d0 pullup", pin_pullup[24], 40'h1);
        rd(8'h30, 32'h02);
        wr(8'h14, 8'hff);
        wr(8'h10, 8'ha5);
        chk("port b oe", pin_oe_n[15:8], 40'h00);
        chk("port b out", pin_out[15:8], 40'ha5);
        periph_en[15:8] <= 8'hff;
        periph_oe[15:8] <= 8'h0f;
        periph_out[15:8] <= 8'h5a;
        step(2);
        chk("owned oe", pin_oe_n[15:8], 40'hf0);
        chk("owned out", pin_out[11:8], 40'ha);
        rd(8'h10, 32'ha5);
        wr(8'h14, 8'h00);
        step(2);
        rd(8'h10, 32'h3a);
        chk("pad sync", pin_sync[15:8], 40'h3a);
        periph_en <= 40'h00_0000_00ff;
        wr(8'h08, 8'hff);
        chk("kbd pullup", pin_pullup[7:0], 40'hff);
        kbd_rising <= 4'ha;
        step(2);
        chk("kbd pulldown", pin_pulldown[7:0], 40'ha0);
        chk("kbd pullup", pin_pullup[7:0], 40'h5f);
        periph_en <= 40'h00_0400_0000;
        irq_rising <= 1'b1;
        wr(8'h38, 8'h04);
        chk("irq pulls", {pin_pulldown[26], pin_pullup[26]}, 40'h2);
        irq_rising <= 1'b0;
        step(2);
        chk("irq pullup", {pin_pulldown[26], pin_pullup[26]}, 40'h1);
        wr(8'h4c, 8'hff);
        rd(8'h4c, 32'h0);
        rd(8'h60, 32'h0);
        sys_rst <= 1'b1;
        step(3);
        chk("oe_n reset", pin_oe_n, 40'hff_ffff_ffff);
        sys_rst <= 1'b0;
        step(1);
        rd(8'h50, 32'h3);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
